// File: cmc_pkg.sv
// Constants, encodings and the state record of the master clock controller.
package cmc_pkg;
  localparam int CNT_W = 9;
  localparam int NPERIPH = 8;
  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_SLOW = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_NONE = 2'h3;
  localparam logic [2:0] DIV_BY8 = 3'h3;
  localparam logic [2:0] TRIM_RESET = 3'h4;
  localparam logic [1:0] LP_WAIT = 2'h0;
  localparam logic [1:0] LP_AHALT_REG_ON = 2'h1;
  localparam logic [1:0] LP_AHALT_REG_OFF = 2'h2;
  localparam logic [1:0] LP_HALT = 2'h3;
  localparam logic PLL_REF_FAST = 1'b0;
  localparam int CLK_MHZ = 200;
  localparam int FAST_RC_KHZ = 16000;
  localparam int SLOW_RC_HZ = 153600;
  localparam int PLL_OUT_MHZ = 96;
  localparam int PLL_REF_KHZ = 16000;
  localparam int EXT_MAX_MASTER_KHZ = 16000;
  localparam int EXT_MAX_REF_KHZ = 24000;
  localparam int SWITCH_GAP_NS = 10;
  localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_STAB_NS = 1000;
  localparam int WAKE_STAB_CYC = (WAKE_STAB_NS * CLK_MHZ + 999) / 1000;
  localparam int CSS_TIMEOUT_NS = 1000;
  localparam int CSS_TIMEOUT_CYC = CSS_TIMEOUT_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    ST_RUN    = 2'h0,
    ST_GAP    = 2'h1,
    ST_LOWPWR = 2'h2,
    ST_STAB   = 2'h3
  } cmc_st_e;

  typedef struct packed {
    cmc_st_e              st;
    logic [1:0]           lpMode;
    logic [1:0]           src;
    logic [2:0]           div;
    logic [1:0]           pendSrc;
    logic [2:0]           pendDiv;
    logic                 pendValid;
    logic                 stabPend;
    logic [1:0]           saveSrc;
    logic [2:0]           saveDiv;
    logic [2:0]           srcEn;
    logic                 coreEn;
    logic [NPERIPH-1:0]   periphEn;
    logic [CNT_W-1:0]     cnt;
    logic                 extPrev;
    logic [CNT_W-1:0]     extIdle;
    logic                 cssFail;
    logic [2:0]           rdy;
    logic [2:0]           trim;
    logic                 pllRef;
    logic                 oscOutEn;
    logic [1:0]           cloSel;
    logic                 cloEn;
    logic                 extRef;
    logic                 regOn;
    logic                 slowOn;
    logic                 retain;
    logic                 bor;
  } cmc_state_s;
endpackage : cmc_pkg

// File: cmc_clock_ctrl.sv
// Master clock source selection, gating and low-power sequencing.
// Function
// RULE1: Reset starts on fast RC divided by eight.
// RULE2: Keep old source until new one ready.
// RULE3: Source change passes through an all-off gap.
// RULE4: Core and each peripheral clock gate separately.
// RULE5: Wakeup first runs fast RC divided by eight; wake from wait keeps the running source.
// RULE6: After stabilisation return to pre-halt source.
// RULE7: External clock failure forces fast RC by eight.
// RULE8: PLL output never a master clock source.
// RULE9: PLL reference selects fast RC or external.
// RULE10: External path: crystal pins or direct input.
// RULE11: Software keeps external master clock below 16MHz.
// RULE12: External reference path for PWM up to 24MHz.
// RULE13: Fast RC is the default master clock.
// RULE14: Fast RC has a writable 3-bit trim.
// RULE15: Slow RC feeds watchdog, wakeup unit, master.
// RULE16: Configurable clock output selects a clock signal.
// RULE17: Wait stops core only; interrupts resume it.
// RULE18: Active-halt stops all; wakes on timer, external.
// RULE19: Active-halt variant turns main regulator off.
// RULE20: Halt stops all, regulator off, external wake.
// RULE21: RAM retention and brownout stay on always.
// RULE22: Oscillator ready and clock failure status visible.
module cmc_clock_ctrl #(
  parameter int STAB_CYC = cmc_pkg::WAKE_STAB_CYC,
  parameter int CSS_CYC  = cmc_pkg::CSS_TIMEOUT_CYC
) (
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  input  wire logic [1:0]                 swSrcSel,
  input  wire logic [2:0]                 swDiv,
  input  wire logic                       swSwitchReq,
  input  wire logic                       fastRcReady,
  input  wire logic                       slowRcReady,
  input  wire logic                       extReady,
  input  wire logic                       extClkIn,
  input  wire logic                       cssEnable,
  input  wire logic                       cssClear,
  input  wire logic                       coreStop,
  input  wire logic [cmc_pkg::NPERIPH-1:0] periphStop,
  input  wire logic [2:0]                 trimIn,
  input  wire logic                       trimWrite,
  input  wire logic                       pllRefSel,
  input  wire logic                       extBypass,
  input  wire logic                       extRefReq,
  input  wire logic [1:0]                 clkOutSel,
  input  wire logic                       clkOutEnable,
  input  wire logic [1:0]                 lpMode,
  input  wire logic                       lpEnter,
  input  wire logic                       wakeIntIrq,
  input  wire logic                       wakeExtIrq,
  input  wire logic                       wakeAutoTimer,
  output logic [2:0]                      masterSrcEn,
  output logic [1:0]                      masterSrc,
  output logic [2:0]                      masterDiv,
  output logic                            coreClkEn,
  output logic [cmc_pkg::NPERIPH-1:0]     periphClkEn,
  output logic [2:0]                      oscReady,
  output logic                            cssFailFlag,
  output logic [2:0]                      fastRcTrim,
  output logic                            pllRefOut,
  output logic                            oscOutPinEn,
  output logic                            extRefEn,
  output logic [1:0]                      clkOutSrc,
  output logic                            clkOutEn,
  output logic                            mainRegOn,
  output logic                            slowRcOn,
  output logic                            ramRetain,
  output logic                            brownoutEn
);
  localparam cmc_pkg::cmc_state_s ST_RESET = '{
    st:       cmc_pkg::ST_RUN,
    src:      cmc_pkg::SRC_FAST,
    div:      cmc_pkg::DIV_BY8,
    srcEn:    3'h1,
    coreEn:   1'b1,
    periphEn: '1,
    trim:     cmc_pkg::TRIM_RESET,
    regOn:    1'b1,
    slowOn:   1'b1,
    retain:   1'b1,
    bor:      1'b1,
    default:  '0
  };

  function automatic logic [2:0] oneHot(input logic [1:0] src);
    oneHot = (src == cmc_pkg::SRC_NONE) ? 3'h0 : 3'h1 << src;
  endfunction : oneHot

  function automatic logic isReady(input logic [2:0] rdy, input logic [1:0] src);
    isReady = |(rdy & oneHot(src));
  endfunction : isReady

  logic [1:0]          rstSync_r;
  logic                rstN;
  cmc_pkg::cmc_state_s s_r;
  cmc_pkg::cmc_state_s s_nxt;
  logic                cssHit;
  logic                wakeGo;
  logic                lpHaltType;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rstSync_r <= 2'h0;
    else
      rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstN = rstSync_r[1];

  localparam logic [cmc_pkg::CNT_W-1:0] CNT_MAX = cmc_pkg::CNT_W'(CSS_CYC);
  // A stuck external clock is seen as no level change for the timeout window.
  assign cssHit = (s_r.src == cmc_pkg::SRC_EXT) && cssEnable && (s_r.extIdle == CNT_MAX); // RULE7
  assign lpHaltType = (s_r.lpMode != cmc_pkg::LP_WAIT);
  always_comb
  begin
    wakeGo = 1'b0;
    case (s_r.lpMode)
      cmc_pkg::LP_WAIT:          wakeGo = wakeIntIrq | wakeExtIrq; // RULE17
      cmc_pkg::LP_AHALT_REG_ON,
      cmc_pkg::LP_AHALT_REG_OFF: wakeGo = wakeAutoTimer | wakeExtIrq; // RULE18
      cmc_pkg::LP_HALT:          wakeGo = wakeExtIrq; // RULE20
      default:                   wakeGo = 1'b0;
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdy = {extReady, slowRcReady, fastRcReady}; // RULE22
    s_nxt.extPrev = extClkIn;
    if (!cssEnable || extClkIn != s_r.extPrev)
      s_nxt.extIdle = '0;
    else if (s_r.extIdle != CNT_MAX)
      s_nxt.extIdle = s_r.extIdle + 1'b1;
    if (cssClear)
      s_nxt.cssFail = 1'b0;
    if (cssHit)
      s_nxt.cssFail = 1'b1; // RULE22
    if (trimWrite)
      s_nxt.trim = trimIn; // RULE14
    s_nxt.pllRef = pllRefSel; // RULE9
    s_nxt.oscOutEn = !extBypass; // RULE10
    // The reference path is not limited to the 16MHz master ceiling.
    s_nxt.extRef = extRefReq; // RULE12
    s_nxt.cloSel = clkOutSel; // RULE16
    s_nxt.cloEn = clkOutEnable; // RULE16
    s_nxt.slowOn = 1'b1; // RULE15
    s_nxt.retain = 1'b1; // RULE21
    s_nxt.bor = 1'b1; // RULE21
    case (s_r.st)
      cmc_pkg::ST_RUN:
      begin
        if (cssHit)
        begin
          s_nxt.src = cmc_pkg::SRC_FAST; // RULE7
          s_nxt.div = cmc_pkg::DIV_BY8;
          s_nxt.pendValid = 1'b0;
          s_nxt.srcEn = 3'h0;
          s_nxt.cnt = '0;
          s_nxt.st = cmc_pkg::ST_GAP;
        end
        else if (lpEnter)
        begin
          s_nxt.lpMode = lpMode;
          s_nxt.saveSrc = s_r.pendValid ? s_r.pendSrc : s_r.src;
          s_nxt.saveDiv = s_r.pendValid ? s_r.pendDiv : s_r.div;
          s_nxt.pendValid = 1'b0;
          s_nxt.st = cmc_pkg::ST_LOWPWR;
        end
        else if (s_r.pendValid && isReady(s_r.rdy, s_r.pendSrc)) // RULE2
        begin
          s_nxt.src = s_r.pendSrc;
          s_nxt.div = s_r.pendDiv;
          s_nxt.pendValid = 1'b0;
          s_nxt.srcEn = 3'h0; // RULE3
          s_nxt.cnt = '0;
          s_nxt.st = cmc_pkg::ST_GAP;
        end
        else if (swSwitchReq && swSrcSel != cmc_pkg::SRC_NONE) // RULE8
        begin
          s_nxt.pendSrc = swSrcSel; // RULE15
          s_nxt.pendDiv = swDiv;
          s_nxt.pendValid = 1'b1;
        end
      end
      cmc_pkg::ST_GAP:
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == cmc_pkg::CNT_W'(cmc_pkg::SWITCH_GAP_CYC - 1))
        begin
          s_nxt.srcEn = oneHot(s_r.src); // RULE3
          s_nxt.cnt = '0;
          s_nxt.stabPend = 1'b0;
          s_nxt.st = s_r.stabPend ? cmc_pkg::ST_STAB : cmc_pkg::ST_RUN;
        end
      end
      cmc_pkg::ST_LOWPWR:
      begin
        if (wakeGo && !lpHaltType)
          s_nxt.st = cmc_pkg::ST_RUN; // RULE17
        else if (wakeGo)
        begin
          s_nxt.src = cmc_pkg::SRC_FAST; // RULE5
          s_nxt.div = cmc_pkg::DIV_BY8;
          s_nxt.srcEn = 3'h0;
          s_nxt.cnt = '0;
          s_nxt.stabPend = 1'b1;
          s_nxt.st = cmc_pkg::ST_GAP;
        end
      end
      cmc_pkg::ST_STAB:
      begin
        s_nxt.cnt = s_r.cnt + 1'b1;
        if (s_r.cnt == cmc_pkg::CNT_W'(STAB_CYC - 1))
        begin
          s_nxt.pendSrc = s_r.saveSrc; // RULE6
          s_nxt.pendDiv = s_r.saveDiv;
          s_nxt.pendValid = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.st = cmc_pkg::ST_RUN;
        end
      end
      default:
        s_nxt = ST_RESET;
    endcase
    s_nxt.coreEn = (s_nxt.st != cmc_pkg::ST_LOWPWR) && !coreStop; // RULE4
    if (s_nxt.st == cmc_pkg::ST_LOWPWR && s_nxt.lpMode != cmc_pkg::LP_WAIT)
      s_nxt.periphEn = '0; // RULE18
    else
      s_nxt.periphEn = ~periphStop; // RULE4
    // Regulator stays on in the fast-wake active-halt so recovery is quick.
    s_nxt.regOn = !(s_nxt.st == cmc_pkg::ST_LOWPWR
                    && (s_nxt.lpMode == cmc_pkg::LP_AHALT_REG_OFF
                        || s_nxt.lpMode == cmc_pkg::LP_HALT)); // RULE19
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      s_r <= ST_RESET; // RULE1
    else
      s_r <= s_nxt;
  end

  // The multiplexer enables are one-hot or all off, so the fast RC is the line at reset.
  assign masterSrcEn = s_r.srcEn; // RULE13
  assign masterSrc   = s_r.src;
  assign masterDiv   = s_r.div;
  assign coreClkEn   = s_r.coreEn;
  assign periphClkEn = s_r.periphEn;
  assign oscReady    = s_r.rdy;
  assign cssFailFlag = s_r.cssFail;
  assign fastRcTrim  = s_r.trim;
  assign pllRefOut   = s_r.pllRef;
  assign oscOutPinEn = s_r.oscOutEn;
  assign extRefEn    = s_r.extRef;
  assign clkOutSrc   = s_r.cloSel;
  assign clkOutEn    = s_r.cloEn;
  assign mainRegOn   = s_r.regOn;
  assign slowRcOn    = s_r.slowOn;
  assign ramRetain   = s_r.retain;
  assign brownoutEn  = s_r.bor;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  property p_reset_fast;
    $rose(rstN) |-> (masterSrcEn == 3'h1 && masterDiv == cmc_pkg::DIV_BY8);
  endproperty
  a_reset_fast: assert property (p_reset_fast) else $error("reset not on fast rc by 8"); // RULE1
  property p_hold_old;
    (s_r.st == cmc_pkg::ST_RUN && s_r.pendValid && !isReady(s_r.rdy, s_r.pendSrc)
     && !cssHit && !lpEnter) |=> $stable(masterSrcEn);
  endproperty
  a_hold_old: assert property (p_hold_old) else $error("switched before ready"); // RULE2
  property p_gap;
    ($changed(masterSrcEn) && masterSrcEn != 3'h0) |-> $past(masterSrcEn) == 3'h0 && $onehot(masterSrcEn);
  endproperty
  a_gap: assert property (p_gap) else $error("clock switch without gap"); // RULE3
  property p_core_stop;
    (coreStop && s_r.st == cmc_pkg::ST_RUN) |=> !coreClkEn;
  endproperty
  a_core_stop: assert property (p_core_stop) else $error("core clock not stopped"); // RULE4
  property p_wake_fast;
    (s_r.st == cmc_pkg::ST_LOWPWR && wakeGo && lpHaltType)
      |=> masterSrcEn == 3'h0 ##[1:4] (masterSrcEn == 3'h1 && masterDiv == cmc_pkg::DIV_BY8);
  endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("wake not on fast rc by 8"); // RULE5
  property p_restore;
    (s_r.st == cmc_pkg::ST_STAB && s_r.cnt == cmc_pkg::CNT_W'(STAB_CYC - 1))
      |=> (s_r.pendValid && s_r.pendSrc == $past(s_r.saveSrc));
  endproperty
  a_restore: assert property (p_restore) else $error("pre-halt source not restored"); // RULE6
  property p_css;
    (cssHit && s_r.st == cmc_pkg::ST_RUN)
      |=> (masterSrcEn == 3'h0 && cssFailFlag) ##[1:4] (masterSrcEn == 3'h1);
  endproperty
  a_css: assert property (p_css) else $error("no fallback on clock failure"); // RULE7
  property p_no_pll;
    (masterSrc != cmc_pkg::SRC_NONE && $onehot(masterSrcEn)) || masterSrcEn == 3'h0;
  endproperty
  a_no_pll: assert property (p_no_pll) else $error("invalid master source"); // RULE8
  property p_lowpwr_gate;
    s_r.st == cmc_pkg::ST_LOWPWR |-> !coreClkEn
      && (s_r.lpMode == cmc_pkg::LP_WAIT || periphClkEn == '0);
  endproperty
  a_lowpwr_gate: assert property (p_lowpwr_gate) else $error("clock running in low power"); // RULE17
  property p_halt_reg;
    (s_r.st == cmc_pkg::ST_LOWPWR && s_r.lpMode == cmc_pkg::LP_HALT) |-> !mainRegOn;
  endproperty
  a_halt_reg: assert property (p_halt_reg) else $error("regulator on in halt"); // RULE20
  property p_retain;
    ramRetain && brownoutEn && slowRcOn;
  endproperty
  a_retain: assert property (p_retain) else $error("retention or brownout off"); // RULE21
  property p_trim;
    trimWrite |=> fastRcTrim == $past(trimIn);
  endproperty
  a_trim: assert property (p_trim) else $error("trim write lost"); // RULE14
  property p_pll_ref;
    1'b1 |=> pllRefOut == $past(pllRefSel);
  endproperty
  a_pll_ref: assert property (p_pll_ref) else $error("pll reference select lost"); // RULE9
  property p_ext_ref;
    1'b1 |=> extRefEn == $past(extRefReq) && oscOutPinEn == !$past(extBypass);
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("external reference path wrong"); // RULE12
  property p_clk_out;
    1'b1 |=> {clkOutEn, clkOutSrc} == $past({clkOutEnable, clkOutSel});
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock output config lost"); // RULE16
  property p_reg_off;
    (s_r.st == cmc_pkg::ST_LOWPWR && s_r.lpMode == cmc_pkg::LP_AHALT_REG_OFF) |-> !mainRegOn;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("regulator on in active halt off"); // RULE19
  property p_css_sticky;
    ((cssFailFlag && !cssClear) || cssHit) |=> cssFailFlag;
  endproperty
  a_css_sticky: assert property (p_css_sticky) else $error("failure flag lost"); // RULE22
  property p_wait_wake;
    (s_r.st == cmc_pkg::ST_LOWPWR && s_r.lpMode == cmc_pkg::LP_WAIT && wakeGo)
      |=> (s_r.st == cmc_pkg::ST_RUN && $stable(masterSrcEn));
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("wait wake failed"); // RULE17

  c_to_ext: cover property (s_r.st == cmc_pkg::ST_GAP ##1 masterSrcEn == 3'h4);
  c_halt_wake: cover property (s_r.st == cmc_pkg::ST_STAB ##1 s_r.st == cmc_pkg::ST_RUN);
  c_css_hit: cover property (cssHit && s_r.st == cmc_pkg::ST_RUN);
  c_wait_wake: cover property (s_r.st == cmc_pkg::ST_LOWPWR ##1 s_r.st == cmc_pkg::ST_RUN);
endmodule : cmc_clock_ctrl

// File: cmc_osc_model.sv
// Oscillator model: fixed RC ready levels and an external clock that halts on command.
module cmc_osc_model #(
  parameter int START = 12
) (
  input  wire logic clock,
  input  wire logic extRun,
  output logic      fastRcReady,
  output logic      slowRcReady,
  output logic      extReady,
  output logic      extClkIn
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  int tog = 0;
  assign fastRcReady = 1'h1;
  assign slowRcReady = 1'h1;
  initial
  begin
    extReady = 1'h0;
    extClkIn = 1'h0;
  end
  // A dead crystal leaves its pin frozen, which is what the monitor must catch.
  always @(posedge clock)
  begin
    if (!extRun)
    begin
      cnt <= 0;
      extReady <= 1'h0;
    end
    else
    begin
      cnt <= cnt + 1;
      extReady <= (cnt >= START);
      tog <= (tog == 6) ? 0 : tog + 1;
      if (tog == 6)
        extClkIn <= ~extClkIn;
    end
  end
endmodule : cmc_osc_model

// File: tb.sv
// Self-checking bench of the master clock controller with its oscillator model.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STAB = 8;
  localparam int CSSC = 16;
  logic clock, rst_b, swSwitchReq, cssEnable, cssClear, coreStop, trimWrite, pllRefSel;
  logic extBypass, extRefReq, clkOutEnable, lpEnter, extRun, wakeIntIrq, wakeExtIrq;
  logic wakeAutoTimer, fastRcReady, slowRcReady, extReady, extClkIn, coreClkEn, cssFailFlag;
  logic pllRefOut, oscOutPinEn, extRefEn, clkOutEn, mainRegOn, slowRcOn, ramRetain, brownoutEn;
  logic [1:0]                  swSrcSel, clkOutSel, lpMode, masterSrc, clkOutSrc;
  logic [2:0]                  swDiv, trimIn, masterSrcEn, masterDiv, oscReady, fastRcTrim;
  logic [cmc_pkg::NPERIPH-1:0] periphStop, periphClkEn;
  int                          failures = 0;
  int                          checksDone = 0;

  cmc_osc_model osc (.clock(clock), .extRun(extRun), .fastRcReady(fastRcReady),
    .slowRcReady(slowRcReady), .extReady(extReady), .extClkIn(extClkIn));
  cmc_clock_ctrl #(.STAB_CYC(STAB), .CSS_CYC(CSSC)) dut (.clock(clock), .rst_b(rst_b),
    .swSrcSel(swSrcSel), .swDiv(swDiv), .swSwitchReq(swSwitchReq), .fastRcReady(fastRcReady),
    .slowRcReady(slowRcReady), .extReady(extReady), .extClkIn(extClkIn),
    .cssEnable(cssEnable), .cssClear(cssClear), .coreStop(coreStop), .periphStop(periphStop),
    .trimIn(trimIn), .trimWrite(trimWrite), .pllRefSel(pllRefSel), .extBypass(extBypass),
    .extRefReq(extRefReq), .clkOutSel(clkOutSel), .clkOutEnable(clkOutEnable),
    .lpMode(lpMode), .lpEnter(lpEnter), .wakeIntIrq(wakeIntIrq), .wakeExtIrq(wakeExtIrq),
    .wakeAutoTimer(wakeAutoTimer), .masterSrcEn(masterSrcEn), .masterSrc(masterSrc),
    .masterDiv(masterDiv), .coreClkEn(coreClkEn), .periphClkEn(periphClkEn),
    .oscReady(oscReady), .cssFailFlag(cssFailFlag), .fastRcTrim(fastRcTrim),
    .pllRefOut(pllRefOut), .oscOutPinEn(oscOutPinEn), .extRefEn(extRefEn),
    .clkOutSrc(clkOutSrc), .clkOutEn(clkOutEn), .mainRegOn(mainRegOn), .slowRcOn(slowRcOn),
    .ramRetain(ramRetain), .brownoutEn(brownoutEn));

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Bounded wait on the mux enables; a hang ends the run instead of stalling it.
  task automatic waitEn(input logic [2:0] exp, input int bound);
    int n = 0;
    while (masterSrcEn !== exp && n < bound)
    begin
      step();
      n++;
    end
    check(masterSrcEn, exp);
    if (masterSrcEn !== exp)
      end_of_test();
  endtask : waitEn

  task automatic req(input logic [1:0] sel, input logic [2:0] div);
    swSrcSel = sel;
    swDiv = div;
    swSwitchReq = 1'h1;
    step();
    swSwitchReq = 1'h0;
  endtask : req

  task automatic wake(input logic [2:0] w);
    {wakeAutoTimer, wakeExtIrq, wakeIntIrq} = w;
    step();
    {wakeAutoTimer, wakeExtIrq, wakeIntIrq} = 3'h0;
  endtask : wake

  task automatic tReset();
    check(masterSrcEn, 3'h1);
    check({masterSrc, masterDiv}, {cmc_pkg::SRC_FAST, cmc_pkg::DIV_BY8});
    check({coreClkEn, periphClkEn}, 9'h1ff);
    check(fastRcTrim, cmc_pkg::TRIM_RESET);
    check({mainRegOn, slowRcOn, ramRetain, brownoutEn, cssFailFlag}, 5'h1e);
    $display("Test reset done");
  endtask : tReset

  task automatic tSwitch();
    req(2'h3, 3'h0);
    repeat (3) step();
    check({masterSrcEn, masterSrc}, 5'h4);
    req(cmc_pkg::SRC_EXT, 3'h1);
    extRun = 1'h1;
    repeat (8) step();
    check(masterSrcEn, 3'h1);
    waitEn(3'h0, 20);
    check({masterSrc, masterDiv}, {cmc_pkg::SRC_EXT, 3'h1});
    step();
    check(masterSrcEn, 3'h0);
    step();
    check(masterSrcEn, 3'h4);
    check(oscReady, 3'h7);
    $display("Test switch done");
  endtask : tSwitch

  task automatic tCss();
    cssEnable = 1'h1;
    repeat (4) step();
    check(masterSrcEn, 3'h4);
    extRun = 1'h0;
    repeat (CSSC - 8) step();
    check(cssFailFlag, 1'h0);
    waitEn(3'h0, 16);
    check({cssFailFlag, masterSrc, masterDiv}, {1'h1, cmc_pkg::SRC_FAST, cmc_pkg::DIV_BY8});
    repeat (2) step();
    check(masterSrcEn, 3'h1);
    cssClear = 1'h1;
    step();
    cssClear = 1'h0;
    step();
    check(cssFailFlag, 1'h0);
    $display("Test monitor done");
  endtask : tCss

  task automatic tMisc();
    {coreStop, trimWrite, pllRefSel, extRefReq, clkOutEnable} = 5'h1f;
    {periphStop, trimIn, clkOutSel, extBypass} = {8'h5a, 3'h2, 2'h2, 1'h0};
    step();
    trimWrite = 1'h0;
    step();
    check({coreClkEn, periphClkEn}, 9'h0a5);
    check(fastRcTrim, 3'h2);
    check({pllRefOut, oscOutPinEn, extRefEn}, 3'h7);
    check({clkOutEn, clkOutSrc}, 3'h6);
    {coreStop, pllRefSel, extRefReq, clkOutEnable, periphStop} = '0;
    {clkOutSel, extBypass} = 3'h3;
    repeat (2) step();
    check({coreClkEn, periphClkEn}, 9'h1ff);
    check({pllRefOut, oscOutPinEn, extRefEn, clkOutEn, clkOutSrc}, 6'h01);
    req(cmc_pkg::SRC_SLOW, 3'h2);
    waitEn(3'h2, 20);
    $display("Test gating done");
  endtask : tMisc

  // Wake vectors are {timer, external, internal}; bad must not wake, good must.
  task automatic lowPower(input logic [1:0] mode, input logic regOn,
                          input logic [7:0] perOn, input logic [2:0] bad, input logic [2:0] good);
    lpMode = mode;
    lpEnter = 1'h1;
    step();
    lpEnter = 1'h0;
    step();
    check({coreClkEn, periphClkEn}, {1'h0, perOn});
    check({mainRegOn, ramRetain, brownoutEn}, {regOn, 2'h3});
    wake(bad);
    step();
    check(coreClkEn, 1'h0);
    wake(good);
    if (mode == cmc_pkg::LP_WAIT)
    begin
      step();
      check(masterSrcEn, 3'h2);
    end
    else
    begin
      waitEn(3'h1, 8);
      check({masterSrc, masterDiv}, {cmc_pkg::SRC_FAST, cmc_pkg::DIV_BY8});
      repeat (STAB - 2) step();
      check(masterSrcEn, 3'h1);
      waitEn(3'h2, 24);
      check({masterSrc, masterDiv}, {cmc_pkg::SRC_SLOW, 3'h2});
    end
    step();
    check({coreClkEn, mainRegOn, periphClkEn}, 10'h3ff);
    $display("Test low power mode %0d done", mode);
  endtask : lowPower

  initial
  begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    $display("Error at %0t: run limit, got %h expected %h", $time, 0, 1);
    failures++;
    end_of_test();
  end

  initial
  begin
    {rst_b, swSwitchReq, cssEnable, cssClear, coreStop, trimWrite, pllRefSel} = '0;
    {extRefReq, clkOutEnable, lpEnter, extRun, wakeIntIrq, wakeExtIrq, wakeAutoTimer} = '0;
    {swSrcSel, clkOutSel, lpMode, swDiv, trimIn, periphStop} = '0;
    extBypass = 1'h1;
    repeat (4) @(posedge clock);
    #1 rst_b = 1'h1;
    repeat (3) step();
    tReset();
    tSwitch();
    tCss();
    tMisc();
    lowPower(cmc_pkg::LP_WAIT, 1'h1, 8'hff, 3'h4, 3'h1);
    lowPower(cmc_pkg::LP_AHALT_REG_ON, 1'h1, 8'h00, 3'h1, 3'h2);
    lowPower(cmc_pkg::LP_AHALT_REG_OFF, 1'h0, 8'h00, 3'h1, 3'h4);
    lowPower(cmc_pkg::LP_HALT, 1'h0, 8'h00, 3'h5, 3'h2);
    end_of_test();
  end
endmodule : tb
